// >>> verilog/wdt_pkg.sv
// constants, field layout and state encoding of the window watchdog
// assumes a single 250 MHz clock and an AXI4-Lite register port
package wdt_pkg;

   localparam int CLK_PERIOD_NS   = 4;
   localparam int NS_PER_MS       = 1000000;
   localparam int FAULT_PULSE_MS  = 2;
   localparam int ACTIVATION_MS   = 30;
   localparam int DEFAULT_SLOW_MS = 10;

   localparam int FAULT_PULSE_CYCLES = FAULT_PULSE_MS * NS_PER_MS / CLK_PERIOD_NS;
   localparam int ACTIVATION_CYCLES  = ACTIVATION_MS * NS_PER_MS / CLK_PERIOD_NS;
   localparam logic [31:0] SLOW_LIMIT_RESET = 32'(DEFAULT_SLOW_MS * NS_PER_MS / CLK_PERIOD_NS);

   // lower window edge is the upper edge divided by eight
   localparam int FAST_DIVIDE_SHIFT = 3;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;

   localparam logic [ADDR_W-1:0] OFF_SLOW_LIMIT    = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_STATUS        = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS    = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK      = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_LAST_INTERVAL = 8'h10;

   localparam int EVT_FAST    = 0;
   localparam int EVT_SLOW    = 1;
   localparam int EVT_MISSING = 2;
   localparam int EVT_W       = 3;
   localparam logic [EVT_W-1:0] IRQ_MASK_RESET = 3'h0;

   localparam int ST_BIT_ARMED = 0;
   localparam int ST_BIT_RESET = 1;
   localparam int ST_BIT_ENPIN = 2;
   localparam int ST_FIELD_LO  = 4;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      WD_OFF        = 3'h0,
      WD_STARTUP    = 3'h1,
      WD_WAIT_FIRST = 3'h3,
      WD_MEASURE    = 3'h2,
      WD_PULSE      = 3'h6
   } wd_state_t;

   function automatic logic [31:0] fast_limit(input logic [31:0] slow);
      return slow >> FAST_DIVIDE_SHIFT;
   endfunction

   function automatic logic [DATA_W-1:0] byte_merge(input logic [DATA_W-1:0] old,
                                                    input logic [DATA_W-1:0] data,
                                                    input logic [STRB_W-1:0] strb);
      logic [DATA_W-1:0] r;
      r = old;
      for (int i = 0; i < STRB_W; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = data[8*i +: 8];
         end
      end
      return r;
   endfunction

endpackage

// >>> verilog/wdt_pulse_timer.sv
// one-shot timer holding active for a loaded number of cycles
// assumes length is at least one and start is not raised while active
`timescale 1ns/100ps
module wdt_pulse_timer (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        start,
   input  wire logic [31:0] length,
   output logic             active,
   output logic             done
);
   logic [31:0] remain;

   // done marks the last active cycle
   assign done = active && (remain == 32'h0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         active <= 1'b0;
         remain <= 32'h0;
      end else if (start) begin
         active <= 1'b1;
         remain <= 32'(length - 32'h1);
      end else if (done) begin
         active <= 1'b0;
      end else if (active) begin
         remain <= 32'(remain - 32'h1);
      end
   end
endmodule

// >>> verilog/window_watchdog_reset.sv
// window watchdog: times the service clock and pulses an active-low reset on a fault
// assumes all inputs synchronous to aclk; registers reached over AXI4-Lite
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
module window_watchdog_reset #(
   parameter int ACTIVATION_CYCLES = wdt_pkg::ACTIVATION_CYCLES,
   parameter int FAULT_CYCLES      = wdt_pkg::FAULT_PULSE_CYCLES
) (
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   input  wire logic [wdt_pkg::ADDR_W-1:0]  awaddr,
   input  wire logic                        awvalid,
   output logic                             awready,
   input  wire logic [wdt_pkg::DATA_W-1:0]  wdata,
   input  wire logic [wdt_pkg::STRB_W-1:0]  wstrb,
   input  wire logic                        wvalid,
   output logic                             wready,
   output logic [1:0]                       bresp,
   output logic                             bvalid,
   input  wire logic                        bready,
   input  wire logic [wdt_pkg::ADDR_W-1:0]  araddr,
   input  wire logic                        arvalid,
   output logic                             arready,
   output logic [wdt_pkg::DATA_W-1:0]       rdata,
   output logic [1:0]                       rresp,
   output logic                             rvalid,
   input  wire logic                        rready,
   input  wire logic                        service_clock_in,
   input  wire logic                        watchdog_enable_n,
   input  wire logic                        low_rail_good,
   input  wire logic                        high_rail_good,
   output logic                             reset_out_n,
   output logic                             irq
);
   import wdt_pkg::*;

   localparam logic [31:0] ACT_LAST  = 32'(ACTIVATION_CYCLES - 1);
   localparam logic [31:0] FAULT_LEN = 32'(FAULT_CYCLES);

   wd_state_t         state;
   wd_state_t         next_state;
   logic [31:0]       cnt;
   logic [31:0]       next_cnt;
   logic              svc_prev;
   logic              fault_missing;
   logic [31:0]       slow_limit;
   logic [31:0]       last_interval;
   logic [EVT_W-1:0]  irq_status;
   logic [EVT_W-1:0]  irq_mask;
   logic              pulse_active;
   logic              pulse_done;

   // watchdog core
   wire rails_good = low_rail_good & high_rail_good;
   wire wd_enabled = ~watchdog_enable_n & rails_good;
   wire svc_rise   = service_clock_in & ~svc_prev;
   wire [31:0] fast_lim = fast_limit(slow_limit);
   wire in_measure = (state == WD_MEASURE) & wd_enabled;
   wire in_wait    = (state == WD_WAIT_FIRST) & wd_enabled;
   wire fast_hit   = in_measure & svc_rise & (cnt < fast_lim);
   wire slow_hit   = in_measure & ~svc_rise & (cnt > slow_limit);
   wire miss_hit   = in_wait & ~svc_rise & (cnt >= slow_limit);
   wire fault_fire = fast_hit | slow_hit | miss_hit;
   wire armed      = (state == WD_WAIT_FIRST) | (state == WD_MEASURE);
   wire [EVT_W-1:0] events = {miss_hit, slow_hit, fast_hit};
   wire [31:0] cnt_inc = (cnt == 32'hffffffff) ? cnt : 32'(cnt + 32'h1);

   always_comb begin
      next_state = state;
      case (state)
         WD_OFF: begin
            if (wd_enabled) next_state = WD_STARTUP;
         end
         WD_STARTUP: begin
            if (!wd_enabled) next_state = WD_OFF;
            else if (cnt == ACT_LAST) next_state = WD_WAIT_FIRST;
         end
         WD_WAIT_FIRST: begin
            if (!wd_enabled) next_state = WD_OFF;
            else if (miss_hit) next_state = WD_PULSE;
            else if (svc_rise) next_state = WD_MEASURE;
         end
         WD_MEASURE: begin
            if (!wd_enabled) next_state = WD_OFF;
            else if (fast_hit || slow_hit) next_state = WD_PULSE;
         end
         WD_PULSE: begin
            // a pulse already started always runs to its full length
            if (pulse_done) begin
               if (!wd_enabled) next_state = WD_OFF;
               else if (fault_missing) next_state = WD_STARTUP;
               else next_state = WD_WAIT_FIRST;
            end
         end
         default: next_state = WD_OFF;
      endcase
   end

   always_comb begin
      if (next_state != state) begin
         next_cnt = (next_state == WD_MEASURE) ? 32'h1 : 32'h0;
      end else if (state == WD_MEASURE && svc_rise) begin
         next_cnt = 32'h1;
      end else if (state == WD_STARTUP || armed) begin
         next_cnt = cnt_inc;
      end else begin
         next_cnt = 32'h0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state    <= WD_OFF;
         cnt      <= 32'h0;
         svc_prev <= 1'b0;
      end else begin
         state    <= next_state;
         cnt      <= next_cnt;
         svc_prev <= service_clock_in;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reset_out_n   <= 1'b1;
         fault_missing <= 1'b0;
         last_interval <= 32'h0;
      end else begin
         reset_out_n <= (next_state != WD_PULSE);
         if (fault_fire) fault_missing <= miss_hit;
         if (in_measure && svc_rise) last_interval <= cnt;
      end
   end

   wdt_pulse_timer u_pulse (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (fault_fire),
      .length  (FAULT_LEN),
      .active  (pulse_active),
      .done    (pulse_done)
   );

   // AXI4-Lite slave
   logic              aw_held;
   logic              w_held;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [STRB_W-1:0] wr_strb;
   logic [DATA_W-1:0] status_word;

   assign awready = ~aw_held & ~bvalid;
   assign wready  = ~w_held & ~bvalid;
   assign arready = ~rvalid;

   wire wr_fire   = aw_held & w_held & ~bvalid;
   wire wr_slow   = wr_fire & (wr_addr == OFF_SLOW_LIMIT);
   wire wr_istat  = wr_fire & (wr_addr == OFF_IRQ_STATUS);
   wire wr_imask  = wr_fire & (wr_addr == OFF_IRQ_MASK);
   wire wr_ro     = wr_fire & ((wr_addr == OFF_STATUS) | (wr_addr == OFF_LAST_INTERVAL));
   wire wr_hit    = wr_slow | wr_istat | wr_imask | wr_ro;
   wire [DATA_W-1:0] slow_merged = byte_merge(slow_limit, wr_data, wr_strb);
   wire [DATA_W-1:0] mask_merged = byte_merge(32'(irq_mask), wr_data, wr_strb);
   wire [DATA_W-1:0] clr_merged  = byte_merge(32'h0, wr_data, wr_strb);
   wire [EVT_W-1:0]  irq_clear   = wr_istat ? clr_merged[EVT_W-1:0] : 3'h0;

   wire rd_slow  = (araddr == OFF_SLOW_LIMIT);
   wire rd_stat  = (araddr == OFF_STATUS);
   wire rd_istat = (araddr == OFF_IRQ_STATUS);
   wire rd_imask = (araddr == OFF_IRQ_MASK);
   wire rd_last  = (araddr == OFF_LAST_INTERVAL);
   wire rd_hit   = rd_slow | rd_stat | rd_istat | rd_imask | rd_last;
   wire [DATA_W-1:0] rd_data = ({DATA_W{rd_slow}} & slow_limit)
                             | ({DATA_W{rd_stat}} & status_word)
                             | ({DATA_W{rd_istat}} & 32'(irq_status))
                             | ({DATA_W{rd_imask}} & 32'(irq_mask))
                             | ({DATA_W{rd_last}} & last_interval);

   always_comb begin
      status_word = 32'h0;
      status_word[ST_BIT_ARMED] = armed;
      status_word[ST_BIT_RESET] = ~reset_out_n;
      status_word[ST_BIT_ENPIN] = watchdog_enable_n;
      status_word[ST_FIELD_LO +: 3] = state;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held   <= 1'b0;
         w_held    <= 1'b0;
         wr_addr   <= 8'h0;
         wr_data   <= 32'h0;
         wr_strb   <= 4'h0;
         bvalid    <= 1'b0;
         bresp     <= RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_held <= 1'b1;
            wr_addr <= awaddr;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
         if (wvalid && wready) begin
            w_held  <= 1'b1;
            wr_data <= wdata;
            wr_strb <= wstrb;
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
         if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0;
         rresp  <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata  <= rd_data;
         rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // registers and interrupt
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slow_limit <= SLOW_LIMIT_RESET;
         irq_mask   <= IRQ_MASK_RESET;
         irq_status <= 3'h0;
         irq        <= 1'b0;
      end else begin
         if (wr_slow) slow_limit <= slow_merged;
         if (wr_imask) irq_mask <= mask_merged[EVT_W-1:0];
         // a new event wins over a clear in the same cycle
         irq_status <= (irq_status & ~irq_clear) | events;
         irq        <= |(((irq_status & ~irq_clear) | events) & irq_mask);
      end
   end

   // checks
   logic [31:0] low_cnt;
   always_ff @(posedge aclk) begin
      if (!aresetn) low_cnt <= 32'h0;
      else low_cnt <= reset_out_n ? 32'h0 : 32'(low_cnt + 32'h1);
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_window_pass: assert property (
      (in_measure && svc_rise && cnt >= fast_lim && cnt <= slow_limit)
      |=> (state == WD_MEASURE && cnt == 32'h1 && last_interval == $past(cnt))
   ) else $error("in-window edge did not restart the interval");

   chk_fast_fault: assert property (
      (in_measure && svc_rise && cnt < fast_limit(slow_limit))
      |=> (state == WD_PULSE && irq_status[EVT_FAST] && !reset_out_n)
   ) else $error("short interval did not raise a fast fault");

   chk_slow_fault: assert property (
      (in_measure && !svc_rise && cnt > slow_limit)
      |=> (state == WD_PULSE && irq_status[EVT_SLOW] && !reset_out_n)
   ) else $error("long interval did not raise a slow fault");

   chk_pulse_width: assert property (
      $rose(reset_out_n) |-> (low_cnt == FAULT_LEN)
   ) else $error("reset pulse length wrong");

   chk_disable_off: assert property (
      (watchdog_enable_n && state != WD_PULSE) |=> (state == WD_OFF && reset_out_n)
   ) else $error("disabled watchdog left idle state");

   chk_startup_delay: assert property (
      (state == WD_WAIT_FIRST && $past(state) == WD_STARTUP)
      |-> ($past(cnt) == ACT_LAST && $past(rails_good))
   ) else $error("armed before activation delay elapsed");

   chk_missing_edge: assert property (
      (in_wait && !svc_rise && cnt >= slow_limit)
      |=> (state == WD_PULSE && fault_missing && irq_status[EVT_MISSING])
   ) else $error("missing edge did not raise a fault");

   chk_fault_repeat: assert property (
      (state == WD_PULSE && pulse_done && fault_missing && wd_enabled)
      |=> (state == WD_STARTUP && cnt == 32'h0) ##1 reset_out_n
   ) else $error("missing-edge cycle did not restart");

   chk_fault_restart: assert property (
      (state == WD_PULSE && pulse_done && !fault_missing && wd_enabled)
      |=> (state == WD_WAIT_FIRST && cnt == 32'h0)
   ) else $error("measurement not restarted after fault");

endmodule

// >>> verification/service_source.sv
// partner model: controller driving the service clock at a chosen period
// assumes period of two cycles or more; line is held low while run is low
`timescale 1ns/100ps
module service_source (
   input  wire logic        aclk,
   input  wire logic        run,
   input  wire logic [15:0] period,
   output logic             service_clock_in
);
   logic [15:0] phase;
   initial begin
      phase = 16'h0000;
      service_clock_in = 1'b0;
   end
   // one rising edge per period while running, stuck low when stopped
   always @(posedge aclk) begin
      if (!run) begin
         phase            <= 16'h0000;
         service_clock_in <= 1'b0;
      end else begin
         phase            <= (phase + 16'h0001 >= period) ? 16'h0000 : phase + 16'h0001;
         service_clock_in <= (phase < (period >> 1));
      end
   end
endmodule

// >>> verification/tb_window_watchdog_reset.sv
// testbench: drives the register port and the service clock of the watchdog
// assumes short activation and pulse counts set through the parameters
`timescale 1ns/100ps
module tb_window_watchdog_reset;
   import wdt_pkg::*;
   localparam int ACT = 40;
   localparam int FLT = 8;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, irq;
   logic        awready, wready, bvalid, arready, rvalid, reset_out_n, svc;
   logic        watchdog_enable_n, low_rail_good, high_rail_good, run;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   logic [15:0] period;
   int          err_total, checks_done, cyc, t1, t2, len;

   window_watchdog_reset #(.ACTIVATION_CYCLES(ACT), .FAULT_CYCLES(FLT)) dut (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .service_clock_in(svc), .watchdog_enable_n(watchdog_enable_n),
      .low_rail_good(low_rail_good), .high_rail_good(high_rail_good),
      .reset_out_n(reset_out_n), .irq(irq));
   service_source partner (.aclk(aclk), .run(run), .period(period), .service_clock_in(svc));

   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   always @(posedge aclk) cyc <= cyc + 1;

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic hang(input string what);
      err_total++;
      $display("mismatch %s expected answer seen timeout", what);
      complete_run();
   endtask
   task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic aw_left, w_left;
      @(posedge aclk);
      aw_left = 1'b1;
      w_left = 1'b1;
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (bvalid === 1'b1) begin
            rs = bresp;
            bready <= 1'b0;
            return;
         end
         if (aw_left && awready === 1'b1) begin
            aw_left = 1'b0;
            awvalid <= 1'b0;
         end
         if (w_left && wready === 1'b1) begin
            w_left = 1'b0;
            wvalid <= 1'b0;
         end
      end
      hang("write response");
   endtask
   task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (rvalid === 1'b1) begin
            v = rdata;
            rs = rresp;
            rready <= 1'b0;
            return;
         end
         if (arready === 1'b1) arvalid <= 1'b0;
      end
      hang("read data");
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
      axi_write(a, v, r);
      check("write resp", 32'(RESP_OKAY), 32'(r));
   endtask
   task automatic reg_read(input logic [7:0] a, input logic [31:0] exp, input string what);
      axi_read(a, d, r);
      check(what, exp, d);
      check("read resp", 32'(RESP_OKAY), 32'(r));
   endtask
   // waits for a reset pulse, retunes the source as it starts, counts its low cycles
   task automatic wait_pulse(input int bound, input logic [15:0] nxt, output int st,
                             output int n);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (n > bound) hang("reset pulse");
      end while (reset_out_n !== 1'b0);
      period <= nxt;
      st = cyc;
      n = 1;
      while (n < FLT + 5) begin
         @(posedge aclk);
         if (reset_out_n !== 1'b0) break;
         n++;
      end
   endtask
   task automatic expect_quiet(input int cycles);
      int lows;
      lows = 0;
      repeat (cycles) begin
         @(posedge aclk);
         if (reset_out_n !== 1'b1) lows++;
      end
      check("low reset cycles", 32'h0, 32'(lows));
   endtask

   task automatic test_registers();
      reg_read(OFF_SLOW_LIMIT, SLOW_LIMIT_RESET, "slow_limit reset");
      reg_read(OFF_IRQ_MASK, 32'h0, "irq_mask reset");
      reg_read(OFF_STATUS, 32'h4, "status reset");
      axi_read(8'h40, d, r);
      check("unmapped data", 32'h0, d);
      check("unmapped read resp", 32'(RESP_SLVERR), 32'(r));
      axi_write(8'h40, 32'h1, r);
      check("unmapped write resp", 32'(RESP_SLVERR), 32'(r));
      reg_write(OFF_SLOW_LIMIT, 32'h40);
      reg_read(OFF_SLOW_LIMIT, 32'h40, "slow_limit");
      reg_write(OFF_IRQ_MASK, 32'h7);
      $display("test registers done");
   endtask
   task automatic test_startup();
      @(posedge aclk);
      watchdog_enable_n <= 1'b0;
      low_rail_good <= 1'b1;
      high_rail_good <= 1'b1;
      repeat (5) @(posedge aclk);
      reg_read(OFF_STATUS, 32'h10, "status startup");
      low_rail_good <= 1'b0;
      repeat (3) @(posedge aclk);
      low_rail_good <= 1'b1;
      t1 = cyc;
      d = 32'h0;
      for (int n = 0; n < 40 && d[ST_BIT_ARMED] !== 1'b1; n++) axi_read(OFF_STATUS, d, r);
      t2 = cyc - t1;
      check("arming delay", 32'h1, 32'(t2 >= ACT && t2 <= ACT + 10));
      run <= 1'b1;
      period <= 16'd8;
      $display("test startup done");
   endtask
   task automatic test_window();
      expect_quiet(48);
      period <= 16'd64;
      expect_quiet(260);
      reg_read(OFF_LAST_INTERVAL, 32'd64, "last_interval");
      $display("test window done");
   endtask
   task automatic test_fast();
      period <= 16'd7;
      wait_pulse(200, 16'd32, t1, len);
      check("fast pulse length", 32'(FLT), 32'(len));
      reg_read(OFF_IRQ_STATUS, 32'h1, "fast event");
      check("irq raised", 32'h1, 32'(irq));
      reg_write(OFF_IRQ_STATUS, 32'h1);
      repeat (2) @(posedge aclk);
      check("irq cleared", 32'h0, 32'(irq));
      expect_quiet(300);
      $display("test fast done");
   endtask
   task automatic test_slow();
      reg_write(OFF_IRQ_MASK, 32'h0);
      period <= 16'd70;
      wait_pulse(300, 16'd32, t1, len);
      check("slow pulse length", 32'(FLT), 32'(len));
      reg_read(OFF_IRQ_STATUS, 32'h2, "slow event");
      check("irq masked", 32'h0, 32'(irq));
      reg_write(OFF_IRQ_STATUS, 32'h2);
      reg_read(OFF_IRQ_STATUS, 32'h0, "events cleared");
      expect_quiet(300);
      $display("test slow done");
   endtask
   task automatic test_missing();
      reg_write(OFF_IRQ_MASK, 32'h7);
      run <= 1'b0;
      wait_pulse(300, 16'd32, t1, len);
      wait_pulse(300, 16'd32, t1, len);
      reg_read(OFF_IRQ_STATUS, 32'h6, "missing event");
      reg_write(OFF_IRQ_STATUS, 32'h7);
      wait_pulse(300, 16'd32, t2, len);
      t2 = t2 - t1;
      check("miss gap", 32'h1, 32'(t2 >= ACT + FLT + 58 && t2 <= ACT + FLT + 70));
      check("missing pulse length", 32'(FLT), 32'(len));
      run <= 1'b1;
      expect_quiet(400);
      $display("test missing done");
   endtask
   task automatic test_disable();
      watchdog_enable_n <= 1'b1;
      run <= 1'b0;
      expect_quiet(400);
      reg_read(OFF_STATUS, 32'h4, "status disabled");
      $display("test disable done");
   endtask

   initial begin
      err_total = 0;
      checks_done = 0;
      aresetn <= 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, run} <= 6'h00;
      {awaddr, araddr, wdata, wstrb} <= 52'h0;
      {low_rail_good, high_rail_good} <= 2'h0;
      watchdog_enable_n <= 1'b1;
      period <= 16'd32;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      test_registers();
      test_startup();
      test_window();
      test_fast();
      test_slow();
      test_missing();
      test_disable();
      complete_run();
   end
endmodule
